// ---- common/drive_input_pkg.sv ----
package drive_input_pkg;
	// ----------------------------------------------------------------
	// Terminal function option codes
	// ----------------------------------------------------------------
	localparam logic [7:0] FUNC_JOG = 8'h06;
	localparam logic [7:0] FUNC_BRAKE = 8'h07;
	localparam logic [7:0] FUNC_SECOND_MOTOR = 8'h08;
	localparam int NUM_SELECTORS = 5;
	localparam int SEL_W = 8;

	// ----------------------------------------------------------------
	// Frequency and parameter scaling (frequency in 0.1 Hz units)
	// ----------------------------------------------------------------
	localparam int FREQ_W = 16;
	localparam logic [15:0] JOG_LIMIT_FREQ = 16'h0064;
	localparam logic [15:0] FREQ_ZERO = 16'h0000;
	localparam int DELAY_W = 6;
	localparam logic [5:0] BRAKE_DELAY_MIN = 6'h01;
	localparam logic [5:0] BRAKE_DELAY_MAX = 6'h32;
	localparam int FORCE_W = 7;
	localparam logic [6:0] BRAKE_FORCE_MAX = 7'h64;

	// ----------------------------------------------------------------
	// Jog stop methods and run sources
	// ----------------------------------------------------------------
	localparam logic [1:0] JOG_STOP_COAST = 2'h0;
	localparam logic [1:0] JOG_STOP_DECEL = 2'h1;
	localparam logic [1:0] JOG_STOP_BRAKE = 2'h2;
	localparam logic [1:0] RUN_SRC_TERMINAL = 2'h1;

	// ----------------------------------------------------------------
	// Timing: delay unit 0.1 s, ramp step period
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int DELAY_UNIT_MS = 100;
	localparam int DELAY_UNIT_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
	localparam int RAMP_STEP_US = 1000;
	localparam int RAMP_STEP_CYCLES = CLK_HZ / 1000000 * RAMP_STEP_US;

	// ----------------------------------------------------------------
	// Drive states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STOP = 3'b000,
		ST_RUN = 3'b001,
		ST_JOG = 3'b010,
		ST_DECEL = 3'b011,
		ST_COAST = 3'b100,
		ST_BRAKE_WAIT = 3'b101,
		ST_BRAKE = 3'b110,
		ST_LOCKOUT = 3'b111
	} drive_state_t;
endpackage : drive_input_pkg

// ---- rtl/drive_input_function_control.sv ----
`timescale 1ns/100ps
module drive_input_function_control
	import drive_input_pkg::*;
#(
	parameter int DELAY_UNIT = DELAY_UNIT_CYCLES,
	parameter int RAMP_STEP = RAMP_STEP_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [NUM_SELECTORS-1:0] i_terminal,
	input wire logic [SEL_W-1:0] i_input_selector_1,
	input wire logic [SEL_W-1:0] i_input_selector_2,
	input wire logic [SEL_W-1:0] i_input_selector_3,
	input wire logic [SEL_W-1:0] i_input_selector_4,
	input wire logic [SEL_W-1:0] i_input_selector_5,
	input wire logic i_forward_run_input,
	input wire logic i_reverse_run_input,
	input wire logic i_keypad_run,
	input wire logic [1:0] i_run_source_select,
	input wire logic [FREQ_W-1:0] i_target_freq,
	input wire logic [FREQ_W-1:0] i_jog_frequency_param,
	input wire logic [FREQ_W-1:0] i_start_frequency_param,
	input wire logic [1:0] i_jog_stop_method,
	input wire logic [DELAY_W-1:0] i_brake_delay_param,
	input wire logic [FORCE_W-1:0] i_brake_force_param,
	output logic [FREQ_W-1:0] o_output_freq,
	output logic o_output_on,
	output logic o_dc_brake_on,
	output logic [FORCE_W-1:0] o_dc_brake_force,
	output logic o_second_motor_active,
	output logic o_running
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// True when any selector routes the wanted function to a live terminal
	function automatic logic func_active(input logic [NUM_SELECTORS-1:0] term,
		input logic [NUM_SELECTORS*SEL_W-1:0] sels, input logic [SEL_W-1:0] code);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < NUM_SELECTORS; k++) begin
			if (term[k] && sels[k*SEL_W +: SEL_W] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : func_active

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_SELECTORS-1:0] term_meta;
		logic [NUM_SELECTORS-1:0] term_sync;
		logic [2:0] run_meta;
		logic [2:0] run_sync;
		drive_state_t state;
		logic [FREQ_W-1:0] freq;
		logic [FREQ_W-1:0] prior_freq;
		logic [31:0] timer;
		logic [DELAY_W-1:0] delay_count;
		logic brake_from_jog;
		logic second_set;
		logic brake_on;
		logic [FORCE_W-1:0] brake_force;
		logic output_on;
		logic running;
	} state_t;

	state_t cur_reg;
	state_t cur_next;

	logic [NUM_SELECTORS*SEL_W-1:0] sel_bus;
	assign sel_bus = {i_input_selector_5, i_input_selector_4, i_input_selector_3,
		i_input_selector_2, i_input_selector_1};

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic jog_in;
		logic brake_in;
		logic second_in;
		logic fwd;
		logic rev;
		logic key;
		logic terminal_run;
		logic run_cmd;
		logic jog_ok;
		logic [FREQ_W-1:0] jog_freq;
		logic [DELAY_W-1:0] delay_lim;
		logic tick;
		jog_in = 1'b0;
		brake_in = 1'b0;
		second_in = 1'b0;
		fwd = 1'b0;
		rev = 1'b0;
		key = 1'b0;
		terminal_run = 1'b0;
		run_cmd = 1'b0;
		jog_ok = 1'b0;
		jog_freq = FREQ_ZERO;
		delay_lim = BRAKE_DELAY_MIN;
		tick = 1'b0;
		cur_next = cur_reg;
		// Pins cross two flip-flops before use
		cur_next.term_meta = i_terminal;
		cur_next.term_sync = cur_reg.term_meta;
		cur_next.run_meta = {i_keypad_run, i_reverse_run_input, i_forward_run_input};
		cur_next.run_sync = cur_reg.run_meta;
		jog_in = func_active(cur_reg.term_sync, sel_bus, FUNC_JOG);
		brake_in = func_active(cur_reg.term_sync, sel_bus, FUNC_BRAKE);
		second_in = func_active(cur_reg.term_sync, sel_bus, FUNC_SECOND_MOTOR);
		fwd = cur_reg.run_sync[0];
		rev = cur_reg.run_sync[1];
		key = cur_reg.run_sync[2];
		// Both directions at once counts as no run at all
		terminal_run = fwd ^ rev;
		// Keypad key only reaches jog in terminal source mode
		run_cmd = terminal_run || (key && i_run_source_select == RUN_SRC_TERMINAL);
		// Jog frequency clamped, then vetted against start frequency
		jog_freq = (i_jog_frequency_param > JOG_LIMIT_FREQ) ? JOG_LIMIT_FREQ
			: i_jog_frequency_param;
		jog_ok = jog_freq != FREQ_ZERO && jog_freq >= i_start_frequency_param;
		// Out-of-range delay and force are clamped to their legal span
		if (i_brake_delay_param < BRAKE_DELAY_MIN) begin
			delay_lim = BRAKE_DELAY_MIN;
		end else if (i_brake_delay_param > BRAKE_DELAY_MAX) begin
			delay_lim = BRAKE_DELAY_MAX;
		end else begin
			delay_lim = i_brake_delay_param;
		end
		cur_next.brake_force = (i_brake_force_param > BRAKE_FORCE_MAX) ? BRAKE_FORCE_MAX
			: i_brake_force_param;
		// Shared timer: ramp steps and 0.1 s delay units
		tick = cur_reg.timer >= 32'(RAMP_STEP - 1);
		cur_next.timer = tick ? 32'h00000000 : cur_reg.timer + 32'h00000001;

		case (cur_reg.state)
			ST_STOP: begin
				cur_next.freq = FREQ_ZERO;
				if (brake_in && terminal_run) begin
					cur_next.prior_freq = FREQ_ZERO;
					cur_next.state = ST_BRAKE;
				end else if (jog_in && run_cmd) begin
					if (jog_ok) begin
						cur_next.freq = jog_freq;
						cur_next.state = ST_JOG;
					end
				end else if (!jog_in && (terminal_run || key)) begin
					cur_next.state = ST_RUN;
				end
			end
			ST_RUN: begin
				// Simple unit-step ramp toward the target
				if (tick && cur_reg.freq < i_target_freq) begin
					cur_next.freq = cur_reg.freq + 16'h0001;
				end else if (tick && cur_reg.freq > i_target_freq) begin
					cur_next.freq = cur_reg.freq - 16'h0001;
				end
				if (brake_in) begin
					cur_next.prior_freq = cur_reg.freq;
					cur_next.brake_from_jog = 1'b0;
					cur_next.delay_count = '0;
					// Keypad run coasts out the delay first, terminal run brakes at once
					cur_next.state = terminal_run ? ST_BRAKE : ST_BRAKE_WAIT;
				end else if (!(terminal_run || key)) begin
					cur_next.state = ST_DECEL;
				end
			end
			ST_JOG: begin
				cur_next.freq = jog_freq;
				if (!jog_in || !run_cmd || !jog_ok) begin
					cur_next.brake_from_jog = 1'b1;
					case (i_jog_stop_method)
						JOG_STOP_COAST: cur_next.state = ST_COAST;
						JOG_STOP_BRAKE: cur_next.state = ST_BRAKE;
						default: cur_next.state = ST_DECEL;
					endcase
				end
			end
			ST_DECEL: begin
				if (cur_reg.freq == FREQ_ZERO) begin
					cur_next.state = ST_STOP;
				end else if (tick) begin
					cur_next.freq = cur_reg.freq - 16'h0001;
				end
			end
			ST_COAST: begin
				// Output off; motor spins down on its own
				cur_next.freq = FREQ_ZERO;
				cur_next.state = ST_STOP;
			end
			ST_BRAKE_WAIT: begin
				cur_next.freq = FREQ_ZERO;
				// Delay units need the timer past the ramp wrap, so it runs on here
				cur_next.timer = cur_reg.timer + 32'h00000001;
				if (!brake_in) begin
					cur_next.state = ST_LOCKOUT;
				end else if (cur_reg.timer >= 32'(DELAY_UNIT - 1)) begin
					cur_next.timer = '0;
					cur_next.delay_count = cur_reg.delay_count + 6'h01;
					if (cur_reg.delay_count + 6'h01 >= delay_lim) begin
						cur_next.state = ST_BRAKE;
					end
				end
			end
			ST_BRAKE: begin
				cur_next.freq = FREQ_ZERO;
				if (cur_reg.brake_from_jog) begin
					// Jog stop brake ends once the jog command is gone; when jog and
					// run drop together this is a single-cycle pulse, the price of
					// tying brake length to the command rather than a timer
					if (!jog_in || !run_cmd) begin
						cur_next.brake_from_jog = 1'b0;
						cur_next.state = ST_STOP;
					end
				end else if (!brake_in) begin
					if (terminal_run) begin
						cur_next.state = ST_RUN;
					end else begin
						cur_next.state = ST_LOCKOUT;
					end
				end
			end
			ST_LOCKOUT: begin
				// Output held off until the run command is withdrawn
				cur_next.freq = FREQ_ZERO;
				if (!key && !terminal_run) begin
					cur_next.state = ST_STOP;
				end
			end
			default: cur_next.state = ST_STOP;
		endcase

		// Terminal run resuming after a brake ramps from zero toward the target frequency
		if (cur_reg.state == ST_BRAKE && cur_next.state == ST_RUN) begin
			cur_next.freq = FREQ_ZERO;
		end
		cur_next.brake_on = cur_next.state == ST_BRAKE;
		cur_next.output_on = cur_next.state == ST_RUN || cur_next.state == ST_JOG
			|| cur_next.state == ST_DECEL;
		cur_next.running = cur_next.state != ST_STOP;
		// Any state without output power shows zero frequency, including the
		// first cycle of a brake, wait or coast entered straight from run or
		// jog; otherwise the braking stage would see a live frequency
		if (!cur_next.output_on) begin
			cur_next.freq = FREQ_ZERO;
		end
		// Set change only lands when idle and at zero frequency
		if (cur_reg.state == ST_STOP && !run_cmd && !key
			&& cur_reg.freq == FREQ_ZERO) begin
			cur_next.second_set = second_in;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign o_output_freq = cur_reg.freq;
	assign o_output_on = cur_reg.output_on;
	assign o_dc_brake_on = cur_reg.brake_on;
	assign o_dc_brake_force = cur_reg.brake_force;
	assign o_second_motor_active = cur_reg.second_set;
	assign o_running = cur_reg.running;

endmodule : drive_input_function_control

// ---- tb/drive_terminal_model.sv ----
`timescale 1ns/100ps
module drive_terminal_model
	import drive_input_pkg::*;
(
	input wire logic [NUM_SELECTORS*SEL_W-1:0] i_sels,
	input wire logic i_jog,
	input wire logic i_brake,
	input wire logic i_second,
	output logic [NUM_SELECTORS-1:0] o_terminal
);
	// ----------------------------------------------------------------
	// Switch wiring
	// ----------------------------------------------------------------
	// Each contact closes for the function its selector names
	// The bench raises jog only with the motor stopped
	// Brake is raised only while the motor runs, never held as a parking brake
	always_comb begin
		o_terminal = '0;
		for (int t = 0; t < NUM_SELECTORS; t++) begin
			o_terminal[t] = (i_sels[t*SEL_W +: SEL_W] == FUNC_JOG && i_jog)
				|| (i_sels[t*SEL_W +: SEL_W] == FUNC_BRAKE && i_brake)
				|| (i_sels[t*SEL_W +: SEL_W] == FUNC_SECOND_MOTOR && i_second);
		end
	end
endmodule : drive_terminal_model

// ---- tb/drive_input_monitor.sv ----
`timescale 1ns/100ps
module drive_input_monitor
	import drive_input_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [FORCE_W-1:0] i_brake_force_param,
	input wire logic [FREQ_W-1:0] o_output_freq,
	input wire logic o_output_on,
	input wire logic o_dc_brake_on,
	input wire logic [FORCE_W-1:0] o_dc_brake_force,
	input wire logic o_second_motor_active,
	input wire logic o_running
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	// Output stayed on over two samples, so no jump is allowed
	sequence s_held_on;
		o_output_on ##1 o_output_on;
	endsequence
	property p_ramp;
		s_held_on |-> o_output_freq <= $past(o_output_freq) + 1
			&& $past(o_output_freq) <= o_output_freq + 1;
	endproperty
	a_ramp: assert property (p_ramp) else $error("freq jumped while on");
	property p_jog_cap;
		$rose(o_output_on) |-> o_output_freq <= JOG_LIMIT_FREQ;
	endproperty
	a_jog_cap: assert property (p_jog_cap) else $error("start above jog cap");
	// Force is clamped; skipped on the edge leaving reset
	property p_force;
		!$past(i_rst) |-> o_dc_brake_force == (($past(i_brake_force_param) > BRAKE_FORCE_MAX)
			? BRAKE_FORCE_MAX : $past(i_brake_force_param));
	endproperty
	a_force: assert property (p_force) else $error("brake force wrong");
	property p_force_cap;
		o_dc_brake_force <= BRAKE_FORCE_MAX;
	endproperty
	a_force_cap: assert property (p_force_cap) else $error("brake force over max");
	property p_brake_zero;
		o_dc_brake_on |-> o_output_freq == FREQ_ZERO && !o_output_on;
	endproperty
	a_brake_zero: assert property (p_brake_zero) else $error("output during brake");
	property p_off_zero;
		!o_output_on |-> o_output_freq == FREQ_ZERO;
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("freq while off");
	property p_running;
		o_output_on || o_dc_brake_on |-> o_running;
	endproperty
	a_running: assert property (p_running) else $error("active while stopped");
	property p_set_hold;
		$changed(o_second_motor_active) |-> !$past(o_running)
			&& $past(o_output_freq) == FREQ_ZERO;
	endproperty
	a_set_hold: assert property (p_set_hold) else $error("set changed running");
endmodule : drive_input_monitor

bind drive_input_function_control drive_input_monitor drive_input_monitor_i (
	.i_clk(i_clk), .i_rst(i_rst), .i_brake_force_param(i_brake_force_param),
	.o_output_freq(o_output_freq), .o_output_on(o_output_on),
	.o_dc_brake_on(o_dc_brake_on), .o_dc_brake_force(o_dc_brake_force),
	.o_second_motor_active(o_second_motor_active), .o_running(o_running));

// ---- tb/drive_input_function_control_tb_top.sv ----
`timescale 1ns/100ps
module drive_input_function_control_tb_top
	import drive_input_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic jog = 1'b0, brk = 1'b0, sec = 1'b0, fwd = 1'b0, rev = 1'b0, key = 1'b0;
	logic [SEL_W-1:0] sel [NUM_SELECTORS] = '{8'h06, 8'h07, 8'h08, 8'h00, 8'h00};
	logic [NUM_SELECTORS-1:0] term;
	logic [FREQ_W-1:0] jfreq = 16'h0032;
	logic [1:0] meth = 2'h0;
	logic [1:0] src = RUN_SRC_TERMINAL;
	logic [DELAY_W-1:0] dly = 6'h00;
	logic [FORCE_W-1:0] frc = 7'h7F;
	logic [FREQ_W-1:0] freq;
	logic on, bon, sm, run;
	logic [FORCE_W-1:0] force_q;
	int err_total = 0, n_compared = 0;
	// Jog table: 5 Hz is the safe unramped setting
	logic [15:0] jf_in [5] = '{16'h0032, 16'h00C8, 16'h0032, 16'h0000, 16'h0004};
	logic [15:0] jf_out [5] = '{16'h0032, 16'h0064, 16'h0032, 16'h0000, 16'h0000};
	logic [1:0] jm [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1};
	// Short counts keep the delay and ramp scenarios brief
	drive_input_function_control #(.DELAY_UNIT(20), .RAMP_STEP(4)) drive_input_function_control_i (
		.i_clk(i_clk), .i_rst(i_rst), .i_terminal(term),
		.i_input_selector_1(sel[0]), .i_input_selector_2(sel[1]),
		.i_input_selector_3(sel[2]), .i_input_selector_4(sel[3]),
		.i_input_selector_5(sel[4]), .i_forward_run_input(fwd),
		.i_reverse_run_input(rev), .i_keypad_run(key),
		.i_run_source_select(src),
		.i_target_freq(16'h0014), .i_jog_frequency_param(jfreq),
		.i_start_frequency_param(16'h0005), .i_jog_stop_method(meth),
		.i_brake_delay_param(dly), .i_brake_force_param(frc),
		.o_output_freq(freq), .o_output_on(on), .o_dc_brake_on(bon),
		.o_dc_brake_force(force_q), .o_second_motor_active(sm), .o_running(run));
	drive_terminal_model drive_terminal_model_i (
		.i_sels({sel[4], sel[3], sel[2], sel[1], sel[0]}),
		.i_jog(jog), .i_brake(brk), .i_second(sec), .o_terminal(term));
	// ----------------------------------------------------------------
	// Clock, tasks and watchdog
	// ----------------------------------------------------------------
	initial begin
		forever #25 i_clk = ~i_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Pins {jog,brake,second,fwd,rev,key} change on a falling edge, then held
	task automatic put(input logic [5:0] v, input int n);
		{jog, brk, sec, fwd, rev, key} = v;
		repeat (n) @(negedge i_clk);
	endtask : put
	// Bounded wait; long enough for a full decel from the jog cap
	task automatic wait_stop;
		for (int k = 0; k < 1200 && run !== 1'b0; k++) @(negedge i_clk);
		check(run, 1'b0);
	endtask : wait_stop
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	initial begin
		#1000000;
		err_total++;
		tally_and_finish();
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(negedge i_clk);
		i_rst = 1'b0;
		put(6'b000000, 2);
		check(force_q, 7'h64);
		check({on, bon, sm, run}, 4'h0);
		frc = 7'h30;
		put(6'b000000, 2);
		check(force_q, 7'h30);
		// Jog limit, no ramp, refusals and every stop method
		for (int e = 0; e < 5; e++) begin
			jfreq = jf_in[e];
			meth = jm[e];
			put(6'b100100, 3);
			check(freq, jf_out[e]);
			check(run, jf_out[e] != 16'h0000);
			put(6'b000000, 3);
			if (jf_out[e] != 16'h0000)
				check({on, bon}, (meth == 2'h0) ? 2'b00 : (meth == 2'h1) ? 2'b10 : 2'b01);
			put(6'b000000, 0);
			wait_stop();
		end
		// Keypad key jogs only in terminal source mode
		jfreq = 16'h0032;
		src = 2'h0;
		put(6'b100001, 6);
		check(run, 1'b0);
		src = RUN_SRC_TERMINAL;
		put(6'b100001, 2);
		check(freq, 16'h0032);
		put(6'b000000, 3);
		wait_stop();
		// Terminal run: brake, then ramp back up from zero to the target frequency
		put(6'b000100, 100);
		check({bon, freq}, {1'b0, 16'h0014});
		put(6'b010100, 3);
		check({bon, on, freq}, {2'b10, 16'h0000});
		put(6'b000100, 3);
		check({bon, on, freq < 16'h0014}, 3'b011);
		put(6'b000100, 100);
		check(freq, 16'h0014);
		put(6'b000110, 0);
		wait_stop();
		put(6'b000110, 10);
		check(run, 1'b0);
		// Second set moved to terminal 5; held off while running
		sel[2] = 8'h00;
		sel[4] = FUNC_SECOND_MOTOR;
		put(6'b000100, 20);
		put(6'b001100, 6);
		check(sm, 1'b0);
		put(6'b001000, 0);
		wait_stop();
		put(6'b001000, 4);
		check(sm, 1'b1);
		put(6'b000000, 4);
		check(sm, 1'b0);
		// Keypad run: coast for the clamped delay, brake, then lockout
		for (int d = 0; d < 2; d++) begin
			dly = d ? 6'h3C : 6'h00;
			put(6'b000001, 100);
			put(6'b010001, 3);
			check({on, bon}, 2'b00);
			put(6'b010001, d ? 990 : 10);
			check(bon, 1'b0);
			put(6'b010001, 20);
			check(bon, 1'b1);
			put(6'b000001, 3);
			check({on, bon}, 2'b00);
			put(6'b000001, 20);
			check(on, 1'b0);
			put(6'b000000, 0);
			wait_stop();
		end
		tally_and_finish();
	end
endmodule : drive_input_function_control_tb_top
